//--- ddcfc_defs.svh
// Purpose: register offsets, field positions, reset values and masks of the downconverter config block
// Assumes: 12-bit register address, 8-bit register data
// Notes: definitions only
`ifndef DDCFC_DEFS_SVH
`define DDCFC_DEFS_SVH

`define DDCFC_ADDR_W 12
`define DDCFC_ADDR_CTRL 12'h310
`define DDCFC_ADDR_INSEL 12'h311
`define DDCFC_ADDR_OSC 12'h314

`define DDCFC_CTRL_RST 8'h00
`define DDCFC_INSEL_RST 8'h00
`define DDCFC_OSC_RST 8'h00
`define DDCFC_CTRL_MASK 8'hFF
`define DDCFC_INSEL_MASK 8'hF5
`define DDCFC_OSC_MASK 8'hFF

`define DDCFC_IFM_HI 5
`define DDCFC_IFM_LO 4
`define DDCFC_C2R_BIT 3
`define DDCFC_DEC_HI 2
`define DDCFC_DEC_LO 0
`define DDCFC_EXT_HI 7
`define DDCFC_EXT_LO 4
`define DDCFC_QSEL_BIT 2
`define DDCFC_ISEL_BIT 0
`define DDCFC_OSC_MODE_HI 7
`define DDCFC_OSC_MODE_LO 4
`define DDCFC_OSC_SEL_HI 3
`define DDCFC_OSC_SEL_LO 0

`define DDCFC_DEC_EXTENDED 3'h7
`define DDCFC_OSC_MODE_DIRECT 4'h0
`define DDCFC_OSC_MODE_PINS 4'h1
`define DDCFC_OSC_MODE_EDGE_A 4'h8
`define DDCFC_OSC_MODE_EDGE_B 4'hA

`define DDCFC_STAGES_RST 7'h03
`define DDCFC_RATIO_RST 6'h04

`endif

//--- ddcfc_pkg.sv
// Purpose: shared types of the downconverter config block
// Assumes: nothing
// Notes: stage bit order is hb1, hb2, hb3, hb4, tb1, tb2, fb2 from bit 0
`default_nettype none

package ddcfc_pkg;

	typedef enum logic [1:0] {
		DDCFC_IF_VARIABLE,
		DDCFC_IF_ZERO,
		DDCFC_IF_QUARTER,
		DDCFC_IF_TEST
	} ddcfc_if_mode_t;

	typedef struct packed {
		logic [6:0] stages;
		logic [5:0] ratio;
		logic known;
		logic half_ok;
	} ddcfc_casc_t;

endpackage : ddcfc_pkg

`default_nettype wire

//--- ddcfc_chan_counter.sv
// Purpose: oscillator channel selection, direct, from pins, or by an edge-driven counter
// Assumes: general inputs synchronous to mclk
// Notes: counter holds its value in non-edge modes
`timescale 1ns/1ps
`default_nettype none
`include "ddcfc_defs.svh"

module ddcfc_chan_counter (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [3:0] sel_mode,
	input wire logic [3:0] sel_field,
	input wire logic general_input_a_zero,
	input wire logic general_input_b_zero,
	output logic [3:0] channel_reg
);

	logic a_prev_reg;
	logic b_prev_reg;
	logic [3:0] count_reg;
	logic [3:0] count_next;
	logic [3:0] channel_next;
	wire rise_a = general_input_a_zero & ~a_prev_reg;
	wire rise_b = general_input_b_zero & ~b_prev_reg;
	wire edge_a_mode = (sel_mode == `DDCFC_OSC_MODE_EDGE_A);
	wire edge_b_mode = (sel_mode == `DDCFC_OSC_MODE_EDGE_B);
	wire step = (edge_a_mode & rise_a) | (edge_b_mode & rise_b); // see RULE_14
	wire at_limit = (count_reg >= sel_field);

	// wrap after the limit value is reached
	assign count_next = step ? (at_limit ? 4'h0 : 4'(count_reg + 4'h1)) : count_reg; // see RULE_13

	assign channel_next = (sel_mode == `DDCFC_OSC_MODE_DIRECT) ? sel_field : // see RULE_12 see RULE_15
		(sel_mode == `DDCFC_OSC_MODE_PINS) ? {2'h0, general_input_b_zero, general_input_a_zero} :
		(edge_a_mode | edge_b_mode) ? count_reg : channel_reg;

	always_ff @(posedge mclk) begin
		if (reset) begin
			a_prev_reg <= 1'b0;
			b_prev_reg <= 1'b0;
			count_reg <= 4'h0;
			channel_reg <= 4'h0;
		end else begin
			a_prev_reg <= general_input_a_zero;
			b_prev_reg <= general_input_b_zero;
			count_reg <= count_next;
			channel_reg <= channel_next;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_count_wrap: assert property (step && at_limit |=> count_reg == 4'h0) // see RULE_13
		else $error("channel counter did not wrap at limit");
	a_count_step: assert property (step && !at_limit |=> count_reg == $past(count_reg) + 4'h1) // see RULE_14
		else $error("channel counter did not advance on edge");
	a_count_idle: assert property (!step |=> $stable(count_reg)) // see RULE_14
		else $error("channel counter moved without a qualifying edge");
	a_direct_sel: assert property (sel_mode == `DDCFC_OSC_MODE_DIRECT |=> channel_reg == $past(sel_field)) // see RULE_12
		else $error("direct channel select not followed");
	a_edge_channel: assert property (edge_a_mode || edge_b_mode |=> channel_reg == $past(count_reg)) // see RULE_13
		else $error("edge mode channel does not show the counter");

endmodule : ddcfc_chan_counter

`default_nettype wire

//--- ddcfc_config.sv
// Purpose: configuration registers and decode for downconverter channel 0
// Assumes: register port synchronous to mclk, read data one cycle after rd_en
// Notes: all outputs are flip-flops; decoded outputs follow register writes after one further cycle, rd_data_reg loads only on rd_en
// Behaviour
// RULE_01 - two-bit offset mode: variable, zero, quarter sample rate, test
// RULE_02 - real output bit clear gives I and Q; set gives real via quarter-rate mix
// RULE_03 - codes 000/001/010 enable halfbands 1-2, 1-3, 1-4; ratios 4, 8, 16, halved real
// RULE_04 - code 011 uses halfband one only; ratio 2, or 1 for real
// RULE_05 - codes 100/101/110 add second third-band stage; ratios 6, 12, 24, halved real
// RULE_06 - main code 111 takes cascade and ratio from extended field
// RULE_07 - extended field ignored unless main code is all ones
// RULE_08 - extended code 0: second third-band plus four halfbands; 48, or 24 real
// RULE_09 - extended 2, 3, 4: fifth-band with one to three halfbands; 10, 20, 40
// RULE_10 - extended 7, 8, 9: first third-band cascades; 3, 15, 30; no halving
// RULE_11 - bit 2 picks Q source, bit 0 picks I source; 0 is A, 1 is B
// RULE_12 - select mode 0 takes oscillator channel straight from channel field
// RULE_13 - edge mode counter wraps to zero after reaching channel field value
// RULE_14 - mode 1000 counts rising edges of input A0, 1010 of input B0
// RULE_15 - four-bit channel field picks one of sixteen oscillator channels
// RULE_16 - reserved bits read zero; unknown extended codes keep the current cascade
// RULE_17 - all fields reset to zero, giving the default configuration
`timescale 1ns/1ps
`default_nettype none
`include "ddcfc_defs.svh"

module ddcfc_config (
	input wire logic mclk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic general_input_a_zero,
	input wire logic general_input_b_zero,
	output logic [7:0] rd_data_reg,
	output ddcfc_pkg::ddcfc_if_mode_t if_mode_reg,
	output logic real_only_reg,
	output logic quarter_mix_en_reg,
	output logic q_output_valid_reg,
	output logic [6:0] stage_en_reg,
	output logic [5:0] decim_ratio_reg,
	output logic real_half_unsupported_reg,
	output logic i_src_b_reg,
	output logic q_src_b_reg,
	output logic [3:0] osc_channel_reg
);

	logic [7:0] ctrl_reg;
	logic [7:0] insel_reg;
	logic [7:0] osc_reg;
	logic [7:0] rd_data_next;
	ddcfc_pkg::ddcfc_casc_t casc;
	logic [6:0] stage_en_next;
	logic [5:0] decim_ratio_next;
	ddcfc_pkg::ddcfc_if_mode_t if_mode_next;
	logic real_only_next;
	logic q_output_valid_next;
	logic real_half_unsupported_next;
	logic i_src_b_next;
	logic q_src_b_next;

	// full cascade decode from main and extended codes
	function automatic ddcfc_pkg::ddcfc_casc_t cascade(input logic [2:0] main_code, input logic [3:0] ext_code);
		ddcfc_pkg::ddcfc_casc_t c;
		c.stages = 7'h00;
		c.ratio = 6'h00;
		c.known = 1'b1;
		c.half_ok = 1'b1;
		case (main_code)
			3'h0: begin
				c.stages = 7'h03; // see RULE_03
				c.ratio = 6'h04;
			end
			3'h1: begin
				c.stages = 7'h07; // see RULE_03
				c.ratio = 6'h08;
			end
			3'h2: begin
				c.stages = 7'h0F; // see RULE_03
				c.ratio = 6'h10;
			end
			3'h3: begin
				c.stages = 7'h01; // see RULE_04
				c.ratio = 6'h02;
			end
			3'h4: begin
				c.stages = 7'h21; // see RULE_05
				c.ratio = 6'h06;
			end
			3'h5: begin
				c.stages = 7'h23; // see RULE_05
				c.ratio = 6'h0C;
			end
			3'h6: begin
				c.stages = 7'h27; // see RULE_05
				c.ratio = 6'h18;
			end
			default: begin
				// extended field consulted only here
				case (ext_code) // see RULE_06 see RULE_07
					4'h0: begin
						c.stages = 7'h2F; // see RULE_08
						c.ratio = 6'h30;
					end
					4'h2: begin
						c.stages = 7'h41; // see RULE_09
						c.ratio = 6'h0A;
					end
					4'h3: begin
						c.stages = 7'h43; // see RULE_09
						c.ratio = 6'h14;
					end
					4'h4: begin
						c.stages = 7'h47; // see RULE_09
						c.ratio = 6'h28;
					end
					4'h7: begin
						c.stages = 7'h10; // see RULE_10
						c.ratio = 6'h03;
						c.half_ok = 1'b0;
					end
					4'h8: begin
						c.stages = 7'h50; // see RULE_10
						c.ratio = 6'h0F;
						c.half_ok = 1'b0;
					end
					4'h9: begin
						c.stages = 7'h52; // see RULE_10
						c.ratio = 6'h1E;
						c.half_ok = 1'b0;
					end
					default: c.known = 1'b0; // see RULE_16
				endcase
			end
		endcase
		return c;
	endfunction : cascade

	// ratio seen at the output, halved when only the real part is sent and half_ok allows it
	function automatic logic [5:0] out_ratio(input logic [5:0] ratio, input logic half_ok, input logic real_out);
		return (real_out && half_ok) ? {1'b0, ratio[5:1]} : ratio;
	endfunction : out_ratio

	wire [2:0] dec_code = ctrl_reg[`DDCFC_DEC_HI:`DDCFC_DEC_LO];
	wire [3:0] ext_code = insel_reg[`DDCFC_EXT_HI:`DDCFC_EXT_LO];
	wire c2r = ctrl_reg[`DDCFC_C2R_BIT];
	wire sel_ctrl = (reg_addr == `DDCFC_ADDR_CTRL);
	wire sel_insel = (reg_addr == `DDCFC_ADDR_INSEL);
	wire sel_osc = (reg_addr == `DDCFC_ADDR_OSC);
	wire sel_none = ~(sel_ctrl | sel_insel | sel_osc);

	assign casc = cascade(dec_code, ext_code);
	// unknown extended codes leave the active cascade untouched
	assign stage_en_next = casc.known ? casc.stages : stage_en_reg; // see RULE_16
	assign decim_ratio_next = casc.known ? out_ratio(casc.ratio, casc.half_ok, c2r) : decim_ratio_reg; // see RULE_03

	assign if_mode_next = ddcfc_pkg::ddcfc_if_mode_t'(ctrl_reg[`DDCFC_IFM_HI:`DDCFC_IFM_LO]); // see RULE_01
	assign real_only_next = c2r; // see RULE_02
	assign q_output_valid_next = ~c2r;
	// an unknown code clears the flag even though the cascade is kept
	assign real_half_unsupported_next = casc.known & ~casc.half_ok & c2r; // see RULE_10
	assign i_src_b_next = insel_reg[`DDCFC_ISEL_BIT]; // see RULE_11
	assign q_src_b_next = insel_reg[`DDCFC_QSEL_BIT];

	// reads of unmapped addresses return zero
	assign rd_data_next = sel_ctrl ? ctrl_reg :
		sel_insel ? insel_reg :
		sel_osc ? osc_reg : 8'h00;

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl_reg <= `DDCFC_CTRL_RST; // see RULE_17
			insel_reg <= `DDCFC_INSEL_RST;
			osc_reg <= `DDCFC_OSC_RST;
		end else if (wr_en) begin
			if (sel_ctrl) begin
				ctrl_reg <= wr_data & `DDCFC_CTRL_MASK;
			end else if (sel_insel) begin
				insel_reg <= wr_data & `DDCFC_INSEL_MASK; // see RULE_16
			end else if (sel_osc) begin
				osc_reg <= wr_data & `DDCFC_OSC_MASK;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rd_data_reg <= 8'h00;
		end else if (rd_en) begin
			rd_data_reg <= rd_data_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			if_mode_reg <= ddcfc_pkg::DDCFC_IF_VARIABLE;
			real_only_reg <= 1'b0;
			quarter_mix_en_reg <= 1'b0;
			q_output_valid_reg <= 1'b1;
			stage_en_reg <= `DDCFC_STAGES_RST;
			decim_ratio_reg <= `DDCFC_RATIO_RST;
			real_half_unsupported_reg <= 1'b0;
			i_src_b_reg <= 1'b0;
			q_src_b_reg <= 1'b0;
		end else begin
			if_mode_reg <= if_mode_next;
			real_only_reg <= real_only_next;
			quarter_mix_en_reg <= real_only_next;
			q_output_valid_reg <= q_output_valid_next;
			stage_en_reg <= stage_en_next;
			decim_ratio_reg <= decim_ratio_next;
			real_half_unsupported_reg <= real_half_unsupported_next;
			i_src_b_reg <= i_src_b_next;
			q_src_b_reg <= q_src_b_next;
		end
	end

	ddcfc_chan_counter u_chan (
		.mclk(mclk),
		.reset(reset),
		.sel_mode(osc_reg[`DDCFC_OSC_MODE_HI:`DDCFC_OSC_MODE_LO]),
		.sel_field(osc_reg[`DDCFC_OSC_SEL_HI:`DDCFC_OSC_SEL_LO]),
		.general_input_a_zero(general_input_a_zero),
		.general_input_b_zero(general_input_b_zero),
		.channel_reg(osc_channel_reg)
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_write_insel;
		wr_en && sel_insel;
	endsequence

	sequence s_quiet;
		!wr_en;
	endsequence

	sequence s_read_insel;
		rd_en && sel_insel;
	endsequence

	sequence s_read_none;
		rd_en && sel_none;
	endsequence

	a_reset_zero: assert property (disable iff (1'b0) reset |=> ctrl_reg == 8'h00 && insel_reg == 8'h00) // see RULE_17
		else $error("fields not zero after reset");
	a_reserved_zero: assert property (insel_reg[3] == 1'b0 && insel_reg[1] == 1'b0) // see RULE_16
		else $error("reserved input select bits not zero");
	a_if_mode: assert property (wr_en |=> ##1 if_mode_reg == $past(ctrl_reg[5:4])) // see RULE_01
		else $error("offset mode output does not follow field");
	a_real_path: assert property (real_only_reg == ~q_output_valid_reg && real_only_reg == quarter_mix_en_reg) // see RULE_02
		else $error("real and complex outputs inconsistent");
	a_main_default: assert property (dec_code == 3'h0 && !c2r |=> stage_en_reg == 7'h03 && decim_ratio_reg == 6'h04) // see RULE_03
		else $error("default cascade wrong");
	a_hb1_real: assert property (dec_code == 3'h3 && c2r |=> stage_en_reg == 7'h01 && decim_ratio_reg == 6'h01) // see RULE_04
		else $error("halfband one real ratio wrong");
	a_tb2_chain: assert property (dec_code == 3'h6 && c2r |=> stage_en_reg == 7'h27 && decim_ratio_reg == 6'h0C) // see RULE_05
		else $error("third-band chain wrong");
	a_ext_ignored: assert property (dec_code != `DDCFC_DEC_EXTENDED |=> stage_en_reg[4] == 1'b0 && stage_en_reg[6] == 1'b0) // see RULE_07
		else $error("extended-only stage enabled without extended code");
	a_ext_48: assert property (dec_code == 3'h7 && ext_code == 4'h0 && !c2r |=> decim_ratio_reg == 6'h30) // see RULE_08
		else $error("extended code 0 ratio wrong");
	a_fifth_band: assert property (dec_code == 3'h7 && ext_code == 4'h4 && c2r |=> stage_en_reg == 7'h47 && decim_ratio_reg == 6'h14) // see RULE_09
		else $error("fifth-band cascade wrong");
	a_tb1_nohalf: assert property (dec_code == 3'h7 && ext_code == 4'h9 && c2r // see RULE_10
		|=> decim_ratio_reg == 6'h1E && real_half_unsupported_reg)
		else $error("first third-band cascade halved");
	a_undef_hold: assert property (dec_code == 3'h7 && ext_code == 4'h5 |=> $stable(stage_en_reg) && $stable(decim_ratio_reg)) // see RULE_16
		else $error("undefined code changed cascade");
	a_input_select: assert property (s_write_insel ##1 s_quiet |=> q_src_b_reg == $past(wr_data[2], 2) && i_src_b_reg == $past(wr_data[0], 2)) // see RULE_11
		else $error("input source select not applied");
	a_reset_outputs: assert property (disable iff (1'b0) reset |=> stage_en_reg == 7'h03 && decim_ratio_reg == 6'h04 // see RULE_17
		&& !real_only_reg && q_output_valid_reg && osc_channel_reg == 4'h0 && rd_data_reg == 8'h00)
		else $error("decoded outputs not at defaults after reset");
	a_insel_stored: assert property (s_write_insel |=> insel_reg == ($past(wr_data) & `DDCFC_INSEL_MASK)) // see RULE_16
		else $error("input select register not stored with reserved bits cleared");
	a_read_insel: assert property (s_read_insel |=> rd_data_reg[3] == 1'b0 && rd_data_reg[1] == 1'b0) // see RULE_16
		else $error("reserved input select bits read back set");
	a_read_none: assert property (s_read_none |=> rd_data_reg == 8'h00) // see RULE_16
		else $error("unmapped read not zero");
	a_real_follow: assert property (real_only_reg == $past(c2r)) // see RULE_02
		else $error("real output flag does not follow its field");
	a_hb3_real: assert property (dec_code == 3'h1 && c2r |=> stage_en_reg == 7'h07 && decim_ratio_reg == 6'h04) // see RULE_03
		else $error("three halfband real cascade wrong");
	a_main_hb4: assert property (dec_code == 3'h2 && !c2r |=> stage_en_reg == 7'h0F && decim_ratio_reg == 6'h10) // see RULE_03
		else $error("four halfband cascade wrong");
	a_hb1_cplx: assert property (dec_code == 3'h3 && !c2r |=> stage_en_reg == 7'h01 && decim_ratio_reg == 6'h02) // see RULE_04
		else $error("halfband one complex ratio wrong");
	a_tb2_hb1: assert property (dec_code == 3'h4 && !c2r |=> stage_en_reg == 7'h21 && decim_ratio_reg == 6'h06) // see RULE_05
		else $error("third-band with halfband one wrong");
	a_tb2_hb2: assert property (dec_code == 3'h5 && !c2r |=> stage_en_reg == 7'h23 && decim_ratio_reg == 6'h0C) // see RULE_05
		else $error("third-band with two halfbands wrong");
	a_ext_used: assert property (dec_code == 3'h7 && ext_code == 4'h3 && !c2r |=> stage_en_reg == 7'h43) // see RULE_06
		else $error("extended field not used under all-ones main code");
	a_ext_48_real: assert property (dec_code == 3'h7 && ext_code == 4'h0 && c2r |=> decim_ratio_reg == 6'h18) // see RULE_08
		else $error("extended code 0 real ratio wrong");
	a_fifth_one: assert property (dec_code == 3'h7 && ext_code == 4'h2 && !c2r |=> stage_en_reg == 7'h41) // see RULE_09
		else $error("fifth-band with halfband one wrong");
	a_fifth_two: assert property (dec_code == 3'h7 && ext_code == 4'h3 && c2r |=> decim_ratio_reg == 6'h0A) // see RULE_09
		else $error("fifth-band with two halfbands real ratio wrong");
	a_tb1_alone: assert property (dec_code == 3'h7 && ext_code == 4'h7 |=> stage_en_reg == 7'h10 && decim_ratio_reg == 6'h03) // see RULE_10
		else $error("first third-band alone wrong");
	a_fifth_tb1: assert property (dec_code == 3'h7 && ext_code == 4'h8 |=> stage_en_reg == 7'h50 && decim_ratio_reg == 6'h0F) // see RULE_10
		else $error("fifth-band with first third-band wrong");

endmodule : ddcfc_config

`default_nettype wire

//--- ddc_filter_chain_config_bench.sv
// Purpose: self-checking bench for the downconverter channel 0 config block
// Assumes: read data one edge after the read strobe, decoded outputs two edges after a write
// Notes: decoded outputs are checked three edges after the write edge
`timescale 1ns/1ps
`default_nettype none

module ddc_filter_chain_config_bench;
	logic mclk, reset, wr_en, rd_en, a0, b0;
	logic [11:0] reg_addr;
	logic [7:0] wr_data, rd_data_reg;
	ddcfc_pkg::ddcfc_if_mode_t if_mode_reg;
	logic real_only_reg, quarter_mix_en_reg, q_output_valid_reg, real_half_unsupported_reg;
	logic i_src_b_reg, q_src_b_reg;
	logic [6:0] stage_en_reg;
	logic [5:0] decim_ratio_reg;
	logic [3:0] osc_channel_reg;
	int n_fail, tests_run;
	// expected stage enables and complex ratios, main codes 0..6 then extended 0,2,3,4,7,8,9
	logic [6:0] main_st [7] = '{7'h03, 7'h07, 7'h0F, 7'h01, 7'h21, 7'h23, 7'h27};
	logic [5:0] main_rt [7] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0C, 6'h18};
	logic [3:0] ext_cd [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
	logic [6:0] ext_st [7] = '{7'h2F, 7'h41, 7'h43, 7'h47, 7'h10, 7'h50, 7'h52};
	logic [5:0] ext_rt [7] = '{6'h30, 6'h0A, 6'h14, 6'h28, 6'h03, 6'h0F, 6'h1E};

	ddcfc_config dut (.mclk(mclk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr),
		.wr_data(wr_data), .general_input_a_zero(a0), .general_input_b_zero(b0), .rd_data_reg(rd_data_reg),
		.if_mode_reg(if_mode_reg), .real_only_reg(real_only_reg), .quarter_mix_en_reg(quarter_mix_en_reg),
		.q_output_valid_reg(q_output_valid_reg), .stage_en_reg(stage_en_reg), .decim_ratio_reg(decim_ratio_reg),
		.real_half_unsupported_reg(real_half_unsupported_reg), .i_src_b_reg(i_src_b_reg),
		.q_src_b_reg(q_src_b_reg), .osc_channel_reg(osc_channel_reg));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr_en <= 1'b1;
		reg_addr <= a;
		wr_data <= d;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr

	task rd_chk(input logic [11:0] a, input logic [7:0] exp);
		@(posedge mclk);
		rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(posedge mclk);
		#1;
		chk(rd_data_reg, exp);
	endtask : rd_chk

	task settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask : settle

	task pulse(input logic on_b);
		@(posedge mclk);
		if (on_b) begin
			b0 <= 1'b1;
		end else begin
			a0 <= 1'b1;
		end
		@(posedge mclk);
		a0 <= 1'b0;
		b0 <= 1'b0;
		@(posedge mclk);
	endtask : pulse

	task test_reset;
		#1;
		chk(8'(stage_en_reg), 8'h03);
		chk(8'(decim_ratio_reg), 8'h04);
		chk({real_only_reg, q_output_valid_reg, i_src_b_reg, q_src_b_reg}, 8'h04);
		chk({8'(if_mode_reg)}, 8'h00);
		chk(8'(osc_channel_reg), 8'h00);
		rd_chk(12'h310, 8'h00);
		rd_chk(12'h311, 8'h00);
		rd_chk(12'h314, 8'h00);
	endtask : test_reset

	task test_main_decim;
		for (int c = 0; c < 2; c++) begin
			for (int d = 0; d < 7; d++) begin
				wr(12'h310, 8'((c << 3) | d));
				settle();
				chk(8'(stage_en_reg), 8'(main_st[d]));
				chk(8'(decim_ratio_reg), 8'(main_rt[d] >> c));
				chk({real_only_reg, quarter_mix_en_reg, q_output_valid_reg}, c ? 8'h06 : 8'h01);
			end
		end
	endtask : test_main_decim

	task test_ext_decim;
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 7; i++) begin
				wr(12'h311, {ext_cd[i], 4'h0});
				wr(12'h310, 8'((c << 3) | 7));
				settle();
				chk(8'(stage_en_reg), 8'(ext_st[i]));
				chk(8'(decim_ratio_reg), 8'((i < 4) ? (ext_rt[i] >> c) : ext_rt[i]));
				chk(8'(real_half_unsupported_reg), 8'((c == 1) && (i >= 4)));
			end
		end
		wr(12'h311, 8'h50);
		settle();
		chk(8'(stage_en_reg), 8'h52);
		chk(8'(decim_ratio_reg), 8'h1E);
		wr(12'h310, 8'h03);
		settle();
		chk(8'(stage_en_reg), 8'h01);
		chk(8'(decim_ratio_reg), 8'h02);
	endtask : test_ext_decim

	task test_mode_and_select;
		for (int m = 0; m < 4; m++) begin
			wr(12'h310, 8'(m << 4));
			settle();
			chk(8'(if_mode_reg), 8'(m));
			rd_chk(12'h310, 8'(m << 4));
		end
		wr(12'h311, 8'hFF);
		rd_chk(12'h311, 8'hF5);
		chk({i_src_b_reg, q_src_b_reg}, 8'h03);
		wr(12'h311, 8'h01);
		settle();
		chk({i_src_b_reg, q_src_b_reg}, 8'h02);
		wr(12'h311, 8'h04);
		settle();
		chk({i_src_b_reg, q_src_b_reg}, 8'h01);
		wr(12'h312, 8'hAA);
		rd_chk(12'h312, 8'h00);
		rd_chk(12'h311, 8'h04);
	endtask : test_mode_and_select

	task test_osc_channel;
		wr(12'h314, 8'h0F);
		settle();
		chk(8'(osc_channel_reg), 8'h0F);
		wr(12'h314, 8'h09);
		settle();
		chk(8'(osc_channel_reg), 8'h09);
		wr(12'h314, 8'h82);
		pulse(1'b0);
		pulse(1'b0);
		settle();
		chk(8'(osc_channel_reg), 8'h02);
		pulse(1'b0);
		settle();
		chk(8'(osc_channel_reg), 8'h00);
		pulse(1'b1);
		pulse(1'b0);
		settle();
		chk(8'(osc_channel_reg), 8'h01);
		wr(12'h314, 8'hA3);
		pulse(1'b0);
		pulse(1'b1);
		pulse(1'b1);
		settle();
		chk(8'(osc_channel_reg), 8'h03);
		pulse(1'b1);
		settle();
		chk(8'(osc_channel_reg), 8'h00);
		wr(12'h314, 8'h1F);
		a0 <= 1'b1;
		settle();
		chk(8'(osc_channel_reg), 8'h01);
		@(posedge mclk);
		a0 <= 1'b0;
		b0 <= 1'b1;
		settle();
		chk(8'(osc_channel_reg), 8'h02);
		@(posedge mclk);
		b0 <= 1'b0;
	endtask : test_osc_channel

	task test_mid_reset;
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		test_reset();
	endtask : test_mid_reset

	task stop_test;
		$display("checks=%0d mismatches=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	initial begin
		#200000;
		n_fail++;
		stop_test();
	end

	initial begin
		n_fail = 0;
		tests_run = 0;
		reset = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		reg_addr = 12'h000;
		wr_data = 8'h00;
		a0 = 1'b0;
		b0 = 1'b0;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		test_reset();
		test_main_decim();
		test_ext_decim();
		test_mode_and_select();
		test_osc_channel();
		test_mid_reset();
		stop_test();
	end
endmodule : ddc_filter_chain_config_bench

`default_nettype wire
